// [testbench/tb.sv]
// Testbench: register map, fault flag and interrupt checks of the status bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fault_crc_pkg::*;
  logic        clk          = 1'b0;
  logic        rst_n        = 1'b0;
  avl_req_t    req          = '0;
  detect_in_t  det          = '0;
  logic [31:0] rdata;
  logic        rvalid;
  logic        wait_req;
  logic        irq;
  logic [31:0] got;
  logic        got_vld;
  logic [11:0] pat;
  logic [7:0]  ro_idx [6]   = '{8'h77, 8'h78, 8'h7B, 8'h7C, 8'h7D, 8'h7E};
  logic [31:0] ro_rst [6]   = '{32'h0000_00B3, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  int          err_count    = 0;
  int          total_checks = 0;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  fault_crc_status_bank u_dut (.clk(clk), .rst_n(rst_n), .avl_req(req), .avl_readdata(rdata),
    .avl_readdatavalid(rvalid), .avl_waitrequest(wait_req), .det(det), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and run end, shared by the main sequence and every timeout
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Word compare; case inequality so unknowns never match
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk_word

  // Single-bit compare for the interrupt line and the read data strobe
  task automatic chk_bit(input string name, input logic exp, input logic seen);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk_bit

  // One Avalon transfer; entered just after a rising edge, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    rd = '0;
    n  = 0;
    req.read      <= ~wr;
    req.write     <= wr;
    req.address   <= {idx, 2'b00};
    req.writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (wait_req !== 1'b0) begin
      err_count++;
      wrap_up();
    end else begin
      // Read data and strobe stand at the accepting edge; one idle edge before the next call
      rd      = rdata;
      got_vld = rvalid;
      req.read  <= 1'b0;
      req.write <= 1'b0;
      @(posedge clk);
    end
  endtask : bus

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string name);
    bus(1'b0, idx, 32'h0, got);
    chk_word(name, exp, got);
    chk_bit("read_valid", 1'b1, got_vld);
  endtask : rd_chk

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard well above the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, then writes of all ones must leave every read-only byte alone
    for (int i = 0; i < 6; i++) begin
      rd_chk(ro_idx[i], ro_rst[i], "reset_value");
      bus(1'b1, ro_idx[i], 32'hFFFF_FFFF, got);
      rd_chk(ro_idx[i], ro_rst[i], "after_write");
    end
    chk_bit("irq_reset", 1'b0, irq);
    bus(1'b1, 8'hFF, 32'hFFFF_FFFF, got);
    rd_chk(8'hFF, RD_UNMAPPED, "unmapped");
    // Masked event sets status only; enabling raises irq; clear drops both
    det.open_fault <= 12'h008;
    repeat (3) @(posedge clk);
    rd_chk(IDX_IRQ_STATUS, 32'h1, "irq_status");
    chk_bit("irq_masked", 1'b0, irq);
    bus(1'b1, IDX_IRQ_ENABLE, 32'h1, got);
    repeat (2) @(posedge clk);
    chk_bit("irq_enabled", 1'b1, irq);
    rd_chk(IDX_IRQ_ENABLE, 32'h1, "irq_enable");
    rd_chk(IDX_IRQ_CLEAR, RD_UNMAPPED, "irq_clear_read");
    bus(1'b1, IDX_IRQ_CLEAR, 32'h1, got);
    repeat (2) @(posedge clk);
    rd_chk(IDX_IRQ_STATUS, 32'h0, "irq_cleared");
    chk_bit("irq_dropped", 1'b0, irq);
    // Walking channel; shorts get the complement so reserved nibbles see ones behind them
    for (int ch = 0; ch < 12; ch++) begin
      pat = 12'h001 << ch;
      det.open_fault  <= pat;
      det.short_fault <= ~pat;
      repeat (2) @(posedge clk);
      rd_chk(IDX_OPEN_FAULT_LOW, {24'h0, pat[7:0]}, "open_low");
      rd_chk(IDX_OPEN_FAULT_HIGH, {28'h0, pat[11:8]}, "open_high");
      rd_chk(IDX_SHORT_FAULT_LOW, {24'h0, ~pat[7:0]}, "short_low");
      rd_chk(IDX_SHORT_FAULT_HIGH, {28'h0, ~pat[11:8]}, "short_high");
    end
    // Flags follow detection, no latching
    det.open_fault  <= 12'h000;
    det.short_fault <= 12'h000;
    repeat (2) @(posedge clk);
    rd_chk(IDX_SHORT_FAULT_LOW, 32'h0, "short_gone");
    bus(1'b1, IDX_IRQ_CLEAR, 32'h7, got);
    // CRC captured only while valid; later changes without valid are dropped
    det.config_crc_result <= 8'h5A;
    det.config_crc_valid  <= 1'b1;
    @(posedge clk);
    det.config_crc_valid  <= 1'b0;
    det.config_crc_result <= 8'h11;
    repeat (2) @(posedge clk);
    rd_chk(IDX_CONFIG_CRC_CALCULATED, 32'h5A, "crc_calc");
    rd_chk(IDX_IRQ_STATUS, 32'h4, "crc_event");
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// [verilog/fault_crc_pkg.sv]
// Package: register map, field layouts and carrier types of the fault and CRC status bank
package fault_crc_pkg;

  // Register indices as printed; the bus byte address is four times the index
  localparam logic [7:0] IDX_EEPROM_CRC_REFERENCE   = 8'h77;
  localparam logic [7:0] IDX_CONFIG_CRC_CALCULATED  = 8'h78;
  localparam logic [7:0] IDX_OPEN_FAULT_LOW         = 8'h7B;
  localparam logic [7:0] IDX_OPEN_FAULT_HIGH        = 8'h7C;
  localparam logic [7:0] IDX_SHORT_FAULT_LOW        = 8'h7D;
  localparam logic [7:0] IDX_SHORT_FAULT_HIGH       = 8'h7E;
  // Interrupt registers placed past the status bank
  localparam logic [7:0] IDX_IRQ_STATUS             = 8'h90;
  localparam logic [7:0] IDX_IRQ_ENABLE             = 8'h91;
  localparam logic [7:0] IDX_IRQ_CLEAR              = 8'h92;

  // Reset values
  localparam logic [7:0]  RST_EEPROM_CRC_REFERENCE  = 8'hB3;
  localparam logic [7:0]  RST_CONFIG_CRC            = 8'h00;
  localparam logic [11:0] RST_FAULT_FLAGS           = 12'h000;
  localparam logic [2:0]  RST_IRQ                   = 3'h0;
  localparam logic [31:0] RD_UNMAPPED               = 32'h0000_0000;

  // Field layout: low byte holds channels 0-7, high byte channels 8-11 in bits 3-0
  localparam int LOW_CH_COUNT  = 8;
  localparam int HIGH_CH_COUNT = 4;

  // Interrupt event bit positions
  localparam int IRQ_BIT_OPEN  = 0;
  localparam int IRQ_BIT_SHORT = 1;
  localparam int IRQ_BIT_CRC   = 2;

  // Avalon-MM request as seen by the slave
  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
  } avl_req_t;

  // Inputs from the detection and CRC logic
  typedef struct packed {
    logic [11:0] open_fault;
    logic [11:0] short_fault;
    logic [7:0]  config_crc_result;
    logic        config_crc_valid;
  } detect_in_t;

  // Whole state of the bank
  typedef struct packed {
    logic [7:0]  nvm_crc_reference_value_q;
    logic [7:0]  config_crc_result_q;
    logic [11:0] open_fault_q;
    logic [11:0] short_fault_q;
    logic [2:0]  irq_status_q;
    logic [2:0]  irq_enable_q;
    logic        irq_q;
    logic [31:0] readdata_q;
    logic        readdatavalid_q;
    logic        waitrequest_q;
  } bank_state_t;

endpackage : fault_crc_pkg

// [verilog/fault_crc_status_bank.sv]
// Module: read-only fault flag and CRC status bank with Avalon-MM slave and interrupt
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// - The EEPROM CRC reference is an 8-bit read-only byte in bits 7-0 that resets to B3h.
// - The CRC calculated over the configuration registers reads as an 8-bit read-only byte in bits 7-0.
// - Open faults of channels 0-7 read as one byte, bit n for channel n, one meaning a fault.
// - Open faults of channels 8-11 read in bits 3-0 of a second byte, bits 7-4 reading zero.
// - Short faults of channels 0-7 read as one byte, bit n for channel n, one meaning a short.
// - Short faults of channels 8-11 read in bits 3-0 of another byte, the upper nibble reading zero.
// - All four fault bytes read zero after reset until detection sets a flag.
module fault_crc_status_bank #(
  parameter int CHANNELS = 12               // LED channel count
) (
  input  wire logic                    clk,               // 100 MHz clock
  input  wire logic                    rst_n,             // Synchronous reset, active low
  input  wire fault_crc_pkg::avl_req_t avl_req,           // Avalon-MM request
  output var  logic [31:0]             avl_readdata,      // Read data
  output var  logic                    avl_readdatavalid, // Read data strobe
  output var  logic                    avl_waitrequest,   // Stall until answer
  input  wire fault_crc_pkg::detect_in_t det,             // Detection results
  output var  logic                    irq                // Level interrupt
);
  import fault_crc_pkg::*;

  // Refuse a channel count the register layout cannot hold
  if (CHANNELS != LOW_CH_COUNT + HIGH_CH_COUNT) begin : g_bad_channels
    $error("CHANNELS must equal twelve");
  end

  bank_state_t s_q;
  bank_state_t s_d;

  // Word address decode: printed index times four
  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hit

  logic        access;
  logic [31:0] rd_word;
  logic [2:0]  events;

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; reserved and unmapped bits read as zero
  always_comb begin
    rd_word = RD_UNMAPPED;
    if (hit(avl_req.address, IDX_EEPROM_CRC_REFERENCE)) begin
      rd_word = {24'h000000, s_q.nvm_crc_reference_value_q};
    end else if (hit(avl_req.address, IDX_CONFIG_CRC_CALCULATED)) begin
      rd_word = {24'h000000, s_q.config_crc_result_q};
    end else if (hit(avl_req.address, IDX_OPEN_FAULT_LOW)) begin
      rd_word = {24'h000000, s_q.open_fault_q[7:0]};
    end else if (hit(avl_req.address, IDX_OPEN_FAULT_HIGH)) begin
      rd_word = {28'h0000000, s_q.open_fault_q[11:8]};
    end else if (hit(avl_req.address, IDX_SHORT_FAULT_LOW)) begin
      rd_word = {24'h000000, s_q.short_fault_q[7:0]};
    end else if (hit(avl_req.address, IDX_SHORT_FAULT_HIGH)) begin
      rd_word = {28'h0000000, s_q.short_fault_q[11:8]};
    end else if (hit(avl_req.address, IDX_IRQ_STATUS)) begin
      rd_word = {29'h0000000, s_q.irq_status_q};
    end else if (hit(avl_req.address, IDX_IRQ_ENABLE)) begin
      rd_word = {29'h0000000, s_q.irq_enable_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    // A request is answered on the cycle after waitrequest falls: one wait cycle always
    access = (avl_req.read || avl_req.write) && s_q.waitrequest_q == 1'b0;
    // Rising flags and a changed CRC raise events
    events[IRQ_BIT_OPEN]  = |(det.open_fault & ~s_q.open_fault_q);
    events[IRQ_BIT_SHORT] = |(det.short_fault & ~s_q.short_fault_q);
    events[IRQ_BIT_CRC]   = det.config_crc_valid && (det.config_crc_result != s_q.config_crc_result_q);

    // Flags mirror detection; no bus path reaches them
    s_d.open_fault_q  = det.open_fault;
    s_d.short_fault_q = det.short_fault;
    if (det.config_crc_valid) begin
      s_d.config_crc_result_q = det.config_crc_result;
    end

    // Handshake: waitrequest high when idle, dropped for one cycle to accept
    s_d.readdatavalid_q = 1'b0;
    s_d.waitrequest_q   = 1'b1;
    if ((avl_req.read || avl_req.write) && s_q.waitrequest_q && !access) begin
      s_d.waitrequest_q = 1'b0;
    end
    if (s_q.waitrequest_q == 1'b0) begin
      s_d.waitrequest_q = 1'b1;
    end
    // Read data loads as waitrequest falls, so it stands at the accepting edge;
    // it is one cycle old by then, which is harmless for status levels
    if (avl_req.read && s_q.waitrequest_q) begin
      s_d.readdata_q      = rd_word;
      s_d.readdatavalid_q = 1'b1;
    end

    // Software writes reach only the enable and clear registers
    if (avl_req.write && !s_q.waitrequest_q) begin
      if (hit(avl_req.address, IDX_IRQ_ENABLE)) begin
        s_d.irq_enable_q = avl_req.writedata[2:0];
      end else if (hit(avl_req.address, IDX_IRQ_CLEAR)) begin
        s_d.irq_status_q = s_q.irq_status_q & ~avl_req.writedata[2:0];
      end
    end
    // Set after clear so a same-cycle event survives
    s_d.irq_status_q = s_d.irq_status_q | events;
    s_d.irq_q = |(s_d.irq_status_q & s_d.irq_enable_q);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.nvm_crc_reference_value_q <= RST_EEPROM_CRC_REFERENCE;
      s_q.config_crc_result_q       <= RST_CONFIG_CRC;
      s_q.open_fault_q              <= RST_FAULT_FLAGS;
      s_q.short_fault_q             <= RST_FAULT_FLAGS;
      s_q.irq_status_q              <= RST_IRQ;
      s_q.irq_enable_q              <= RST_IRQ;
      s_q.irq_q                     <= 1'b0;
      s_q.readdata_q                <= RD_UNMAPPED;
      s_q.readdatavalid_q           <= 1'b0;
      s_q.waitrequest_q             <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign avl_readdata      = s_q.readdata_q;
  assign avl_readdatavalid = s_q.readdatavalid_q;
  assign avl_waitrequest   = s_q.waitrequest_q;
  assign irq               = s_q.irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_crc_ref_const: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.nvm_crc_reference_value_q == RST_EEPROM_CRC_REFERENCE)
    else $error("crc reference changed");

  a_crc_capture: assert property (@(posedge clk) disable iff (!rst_n)
    det.config_crc_valid |=> s_q.config_crc_result_q == $past(det.config_crc_result))
    else $error("crc result not captured");

  a_open_low_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_OPEN_FAULT_LOW)
    |-> avl_readdatavalid && avl_readdata == {24'h000000, $past(s_q.open_fault_q[7:0])})
    else $error("open low read wrong");

  a_open_high_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_OPEN_FAULT_HIGH)
    |-> avl_readdata[31:4] == 28'h0000000 && avl_readdata[3:0] == $past(s_q.open_fault_q[11:8]))
    else $error("open high read wrong");

  a_short_low_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_SHORT_FAULT_LOW)
    |-> avl_readdata == {24'h000000, $past(s_q.short_fault_q[7:0])})
    else $error("short low read wrong");

  a_short_high_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_SHORT_FAULT_HIGH)
    |-> avl_readdata[31:4] == 28'h0000000 && avl_readdata[3:0] == $past(s_q.short_fault_q[11:8]))
    else $error("short high read wrong");

  a_flags_reset: assert property (@(posedge clk)
    !rst_n |=> s_q.open_fault_q == RST_FAULT_FLAGS && s_q.short_fault_q == RST_FAULT_FLAGS)
    else $error("flags not cleared by reset");

  a_flags_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 s_q.open_fault_q == $past(det.open_fault) && s_q.short_fault_q == $past(det.short_fault))
    else $error("flags do not follow detection");

  a_wait_bounded: assert property (@(posedge clk) disable iff (!rst_n)
    (avl_req.read || avl_req.write) |-> ##[0:2] !avl_waitrequest)
    else $error("waitrequest never fell");

  // Handshake: one wait cycle, then a one-cycle accept
  // Read data and its strobe ride on the accept cycle itself
  a_wait_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (avl_req.read || avl_req.write) && avl_waitrequest |=> !avl_waitrequest)
    else $error("waitrequest did not fall");

  a_wait_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    !avl_waitrequest |=> avl_waitrequest)
    else $error("waitrequest low too long");

  a_wait_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !avl_req.read && !avl_req.write |=> avl_waitrequest)
    else $error("waitrequest low without request");

  a_rvalid_set: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && avl_waitrequest |=> avl_readdatavalid)
    else $error("read data strobe missing");

  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    avl_readdatavalid |-> !avl_waitrequest ##1 !avl_readdatavalid)
    else $error("read data strobe misplaced");

  a_write_no_rvalid: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.write && !avl_req.read && avl_waitrequest |=> !avl_readdatavalid)
    else $error("read data strobe on a write");

  a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(avl_req.read && avl_waitrequest) |=> $stable(avl_readdata))
    else $error("read data changed without a read");

  // Reset state; checked without disable so the reset edge itself is seen
  // A missing reset here would show a false interrupt at power-up
  a_reset_outputs: assert property (@(posedge clk)
    !rst_n |=> avl_waitrequest && !avl_readdatavalid && !irq)
    else $error("outputs not reset");

  a_ref_reset: assert property (@(posedge clk)
    !rst_n |=> s_q.nvm_crc_reference_value_q == RST_EEPROM_CRC_REFERENCE)
    else $error("crc reference not reset");

  // Register reads at the accept edge
  // Address is held by the master until acceptance, so it still names the word read
  a_crc_ref_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_EEPROM_CRC_REFERENCE)
    |-> avl_readdata == {24'h000000, RST_EEPROM_CRC_REFERENCE})
    else $error("crc reference read wrong");

  a_crc_calc_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_CONFIG_CRC_CALCULATED)
    |-> avl_readdata == {24'h000000, $past(s_q.config_crc_result_q)})
    else $error("crc result read wrong");

  a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_IRQ_STATUS)
    |-> avl_readdata == {29'h0000000, $past(s_q.irq_status_q)})
    else $error("status read wrong");

  a_enable_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_IRQ_ENABLE)
    |-> avl_readdata == {29'h0000000, $past(s_q.irq_enable_q)})
    else $error("enable read wrong");

  a_clear_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && hit(avl_req.address, IDX_IRQ_CLEAR)
    |-> avl_readdata == RD_UNMAPPED)
    else $error("clear register not write-only");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.read && !avl_waitrequest && avl_req.address[9:2] > IDX_IRQ_CLEAR
    |-> avl_readdata == RD_UNMAPPED)
    else $error("unmapped read not zero");

  // CRC bytes: capture only while valid, never from the bus
  a_crc_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !det.config_crc_valid |=> $stable(s_q.config_crc_result_q))
    else $error("crc result moved without valid");

  a_ref_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.write && !avl_waitrequest |=> $stable(s_q.nvm_crc_reference_value_q))
    else $error("write reached crc reference");

  // Interrupt status: set by events, sticky, set beats clear
  // Software sees a fault edge even if the flag has dropped again
  a_open_event: assert property (@(posedge clk) disable iff (!rst_n)
    |(det.open_fault & ~s_q.open_fault_q) |=> s_q.irq_status_q[IRQ_BIT_OPEN])
    else $error("open event not recorded");

  a_short_event: assert property (@(posedge clk) disable iff (!rst_n)
    |(det.short_fault & ~s_q.short_fault_q) |=> s_q.irq_status_q[IRQ_BIT_SHORT])
    else $error("short event not recorded");

  a_crc_event: assert property (@(posedge clk) disable iff (!rst_n)
    det.config_crc_valid && det.config_crc_result != s_q.config_crc_result_q
    |=> s_q.irq_status_q[IRQ_BIT_CRC])
    else $error("crc event not recorded");

  a_open_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (det.open_fault & ~s_q.open_fault_q) == 12'h000 && !s_q.irq_status_q[IRQ_BIT_OPEN]
    |=> !s_q.irq_status_q[IRQ_BIT_OPEN])
    else $error("open status set without event");

  a_short_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (det.short_fault & ~s_q.short_fault_q) == 12'h000 && !s_q.irq_status_q[IRQ_BIT_SHORT]
    |=> !s_q.irq_status_q[IRQ_BIT_SHORT])
    else $error("short status set without event");

  a_crc_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !det.config_crc_valid && !s_q.irq_status_q[IRQ_BIT_CRC] |=> !s_q.irq_status_q[IRQ_BIT_CRC])
    else $error("crc status set without valid");

  a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    !(avl_req.write && !avl_waitrequest && hit(avl_req.address, IDX_IRQ_CLEAR))
    |=> (s_q.irq_status_q & $past(s_q.irq_status_q)) == $past(s_q.irq_status_q))
    else $error("status bit lost without clear");

  a_clear_works: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.write && !avl_waitrequest && hit(avl_req.address, IDX_IRQ_CLEAR)
    |=> (s_q.irq_status_q & $past(avl_req.writedata[2:0]) & ~$past(events)) == 3'h0)
    else $error("status clear failed");

  // Enable register and the level output
  a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
    avl_req.write && !avl_waitrequest && hit(avl_req.address, IDX_IRQ_ENABLE)
    |=> s_q.irq_enable_q == $past(avl_req.writedata[2:0]))
    else $error("enable write lost");

  a_enable_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(avl_req.write && !avl_waitrequest && hit(avl_req.address, IDX_IRQ_ENABLE))
    |=> $stable(s_q.irq_enable_q))
    else $error("enable changed without write");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(s_q.irq_status_q & s_q.irq_enable_q))
    else $error("interrupt level wrong");

endmodule : fault_crc_status_bank
`default_nettype wire
